// >>> logic/ethp_port.sv
// Purpose: Pin group between the MAC and an external PHY, MII or RMII.
// Assumes: Link clocks come from the PHY; board feeds reference clock
//   to both link clock ports in RMII mode.
// Notes: Byte crossings use toggles; no frame buffering.
`timescale 1ns/1ps

// Operation
// (R1) Drive mgmt clock; sample data on rising edge
// (R2) Mgmt data line carries both directions
// (R3) PHY holds collision until it vanishes
// (R4) PHY transmit clock times enable and data
// (R5) Nibble sent with transmit clock, PHY rising
// (R6) Reduced mode drives only two transmit lines
// (R7) Transmit enable marks activity, clock synchronous
// (R8) PHY receive clock samples received data
// (R9) Reduced mode uses 50 MHz reference clock
// (R10) Nibble counted only while data valid
// (R11) Reduced mode takes only two receive lines
// (R12) PHY holds data valid for the frame
// (R13) Carrier/valid drops only on nibble boundaries
// (R14) Held receive error reports CRC error
// (R15) Configuration selects MII or RMII widths, clocks
module ethp_port (
  // System
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_rmii_mode,
  // Link clocks from the PHY
  input wire logic i_tx_link_clk,
  input wire logic i_rx_link_clk,
  // MAC transmit stream
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_tx_last,
  output logic o_tx_ready,
  output logic o_tx_underrun,
  // MAC receive stream
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte,
  output logic o_rx_end,
  output logic o_rx_crc_err,
  // Management command
  input wire logic i_mgmt_start,
  input wire logic i_mgmt_read,
  input wire logic [4:0] i_mgmt_phy,
  input wire logic [4:0] i_mgmt_reg,
  input wire logic [15:0] i_mgmt_wdata,
  output logic o_mgmt_busy,
  output logic o_mgmt_done,
  output logic [15:0] o_mgmt_rdata,
  // Line status
  output logic o_collision,
  output logic o_carrier,
  // PHY pins
  output logic o_mgmt_clock_out,
  input wire logic i_mgmt_data_io,
  output logic o_mgmt_data_io,
  output logic o_mgmt_data_oe,
  input wire logic i_collision_in,
  input wire logic i_carrier_sense_in,
  output logic [3:0] o_tx_data_bus,
  output logic o_tx_enable_out,
  input wire logic [3:0] i_rx_data_bus,
  input wire logic i_rx_data_valid,
  input wire logic i_rx_error_in
);
  import ethp_pkg::*;

  logic [1:0] rst_s_r;
  logic rst_n;
  logic mode_r;
  // Synchronisers
  logic [SY_W-1:0] ps1_r, ps2_r, ps3_r, held_r, held_nxt, evt;
  logic [SY_W-1:0] raw_in;
  // Transmit handshake
  logic ready_nxt, req_tog_r, req_tog_nxt, last_r, last_nxt, und_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic tx_ack_tog, tx_und_tog;
  // Receive hand-off
  logic rx_btog, rx_etog, rx_eerr;
  logic [7:0] rx_byte_x;
  logic rxv_nxt, rxe_nxt, rxerr_nxt;
  logic [7:0] rxb_nxt;
  // Management
  ethp_mg_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [5:0] bit_r, bit_nxt, bit_inc;
  logic [63:0] frame_r, frame_nxt;
  logic mdc_nxt, oe_nxt, rd_r, rd_nxt, busy_nxt, done_nxt;
  logic [15:0] rdata_nxt;

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rst_s_r <= RST_SYNC_RST;
    else
      rst_s_r <= {rst_s_r[0], 1'b1};
  end
  assign rst_n = rst_s_r[1];

  // Link-side logic; mode is handed over as a level
  ethp_tx u_tx (
    .i_tx_clk (i_tx_link_clk),
    .i_rst_n (rst_n),
    .i_rmii_mode (mode_r),
    .i_req_tog (req_tog_r),
    .i_byte (byte_r),
    .i_last (last_r),
    .o_ack_tog (tx_ack_tog),
    .o_und_tog (tx_und_tog),
    .o_tx_data (o_tx_data_bus),
    .o_tx_en (o_tx_enable_out)
  );

  ethp_rx u_rx (
    .i_rx_clk (i_rx_link_clk),
    .i_rst_n (rst_n),
    .i_rmii_mode (mode_r),
    .i_rx_data (i_rx_data_bus),
    .i_rx_dv (i_rx_data_valid),
    .i_rx_err (i_rx_error_in),
    .o_byte_tog (rx_btog),
    .o_byte (rx_byte_x),
    .o_end_tog (rx_etog),
    .o_end_err (rx_eerr)
  );

  // Pins and toggles from other domains
  always_comb
  begin
    raw_in = '0;
    raw_in[SY_CRS] = i_carrier_sense_in;
    raw_in[SY_COL] = i_collision_in; // [R3]
    raw_in[SY_MDIO] = i_mgmt_data_io;
    raw_in[SY_ACK] = tx_ack_tog;
    raw_in[SY_UND] = tx_und_tog;
    raw_in[SY_RXB] = rx_btog;
    raw_in[SY_RXE] = rx_etog;
    for (int i = 0; i < SY_W; i++)
      held_nxt[i] = ethp_agree(ps2_r[i], ps3_r[i], held_r[i]);
    evt = held_nxt ^ held_r;
  end

  // Transmit byte hand-over, held until the link side takes it
  always_comb
  begin
    ready_nxt = o_tx_ready;
    req_tog_nxt = req_tog_r;
    byte_nxt = byte_r;
    last_nxt = last_r;
    und_nxt = evt[SY_UND];
    if (o_tx_ready && i_tx_valid)
    begin
      ready_nxt = 1'b0;
      byte_nxt = i_tx_byte;
      last_nxt = i_tx_last;
      req_tog_nxt = ~req_tog_r; // [R5]
    end
    else if (evt[SY_ACK])
      ready_nxt = 1'b1;
  end

  // Receive hand-off; the byte word is stable for a whole byte time
  always_comb
  begin
    rxv_nxt = evt[SY_RXB];
    rxb_nxt = evt[SY_RXB] ? rx_byte_x : o_rx_byte; // [R10]
    rxe_nxt = evt[SY_RXE];
    rxerr_nxt = evt[SY_RXE] & rx_eerr; // [R14]
  end

  // Management frame: bits change on falling edges
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    mdc_nxt = o_mgmt_clock_out;
    bit_nxt = bit_r;
    bit_inc = bit_r + 6'h1;
    frame_nxt = frame_r;
    oe_nxt = o_mgmt_data_oe;
    rd_nxt = rd_r;
    busy_nxt = o_mgmt_busy;
    done_nxt = 1'b0;
    rdata_nxt = o_mgmt_rdata;
    case (st_r)
      ETHP_MG_IDLE:
      begin
        if (i_mgmt_start)
        begin
          st_nxt = ETHP_MG_RUN;
          busy_nxt = 1'b1;
          cnt_nxt = 4'h0;
          mdc_nxt = 1'b0;
          bit_nxt = 6'h0;
          rd_nxt = i_mgmt_read;
          oe_nxt = 1'b1; // [R2]
          if (i_mgmt_read)
            frame_nxt = {MG_PREAMBLE, MG_START, MG_OP_RD, i_mgmt_phy,
                         i_mgmt_reg, MG_TA_RD, MG_IDLE_DATA};
          else
            frame_nxt = {MG_PREAMBLE, MG_START, MG_OP_WR, i_mgmt_phy,
                         i_mgmt_reg, MG_TA_WR, i_mgmt_wdata};
        end
      end
      ETHP_MG_RUN:
      begin
        if (cnt_r == MDC_HALF_M1)
        begin
          cnt_nxt = 4'h0;
          mdc_nxt = ~o_mgmt_clock_out; // [R1]
          if (!o_mgmt_clock_out)
          begin
            // Rising edge: capture read data
            if (rd_r && bit_r >= MG_DATA_BIT)
              rdata_nxt = {o_mgmt_rdata[14:0], held_r[SY_MDIO]}; // [R1]
          end
          else if (bit_r == MG_LAST_BIT)
          begin
            st_nxt = ETHP_MG_IDLE;
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            oe_nxt = 1'b0;
          end
          else
          begin
            bit_nxt = bit_inc;
            frame_nxt = {frame_r[62:0], 1'b1};
            // Release the line from turnaround on for reads
            oe_nxt = !(rd_r && bit_inc >= MG_TA_BIT); // [R2]
          end
        end
        else
          cnt_nxt = cnt_r + 4'h1;
      end
      default:
        st_nxt = ETHP_MG_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r <= 1'b0;
      ps1_r <= '0;
      ps2_r <= '0;
      ps3_r <= '0;
      held_r <= '0;
      o_tx_ready <= TX_READY_RST;
      req_tog_r <= 1'b0;
      byte_r <= 8'h00;
      last_r <= 1'b0;
      o_tx_underrun <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_byte <= 8'h00;
      o_rx_end <= 1'b0;
      o_rx_crc_err <= 1'b0;
      st_r <= ETHP_MG_IDLE;
      cnt_r <= 4'h0;
      bit_r <= 6'h0;
      frame_r <= 64'h0000_0000_0000_0000;
      rd_r <= 1'b0;
      o_mgmt_clock_out <= 1'b0;
      o_mgmt_data_oe <= 1'b0;
      o_mgmt_busy <= 1'b0;
      o_mgmt_done <= 1'b0;
      o_mgmt_rdata <= 16'h0000;
    end
    else
    begin
      mode_r <= i_rmii_mode; // [R15]
      ps1_r <= raw_in;
      ps2_r <= ps1_r;
      ps3_r <= ps2_r;
      held_r <= held_nxt;
      o_tx_ready <= ready_nxt;
      req_tog_r <= req_tog_nxt;
      byte_r <= byte_nxt;
      last_r <= last_nxt;
      o_tx_underrun <= und_nxt;
      o_rx_valid <= rxv_nxt;
      o_rx_byte <= rxb_nxt;
      o_rx_end <= rxe_nxt;
      o_rx_crc_err <= rxerr_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      frame_r <= frame_nxt;
      rd_r <= rd_nxt;
      o_mgmt_clock_out <= mdc_nxt;
      o_mgmt_data_oe <= oe_nxt;
      o_mgmt_busy <= busy_nxt;
      o_mgmt_done <= done_nxt;
      o_mgmt_rdata <= rdata_nxt;
    end
  end

  assign o_mgmt_data_io = frame_r[63];
  assign o_collision = held_r[SY_COL];
  assign o_carrier = held_r[SY_CRS];

  a_mdc_idle_low: assert property (@(posedge i_clk) // [R1]
    disable iff (!rst_n) (st_r == ETHP_MG_IDLE) |-> !o_mgmt_clock_out)
    else $error("management clock runs while idle");

  a_mdc_high_time: assert property (@(posedge i_clk) // [R1]
    disable iff (!rst_n) $rose(o_mgmt_clock_out) |->
      o_mgmt_clock_out [*8] ##1 !o_mgmt_clock_out)
    else $error("management clock high time not eight cycles");

  a_mdio_read_release: assert property (@(posedge i_clk) // [R2]
    disable iff (!rst_n)
    (o_mgmt_busy && rd_r && bit_r >= MG_TA_BIT) |-> !o_mgmt_data_oe)
    else $error("data line driven during read turnaround or data");

  a_mdio_write_drive: assert property (@(posedge i_clk) // [R2]
    disable iff (!rst_n) (o_mgmt_busy && !rd_r) |-> o_mgmt_data_oe)
    else $error("data line released during a write frame");

  a_tx_take_byte: assert property (@(posedge i_clk) // [R5]
    disable iff (!rst_n) (o_tx_ready && i_tx_valid) |=>
      (!o_tx_ready && req_tog_r != $past(req_tog_r)))
    else $error("accepted byte not handed to the link side");

  a_rx_err_end: assert property (@(posedge i_clk) // [R14]
    disable iff (!rst_n) o_rx_crc_err |-> o_rx_end)
    else $error("CRC error flagged outside frame end");

endmodule : ethp_port

// >>> logic/ethp_pkg.sv
// Purpose: Shared constants and types for the PHY pin port.
// Assumes: System clock of 40 MHz; link clocks come from the PHY.
// Notes: Management frames are 64 bits, led by a 32-bit preamble.
package ethp_pkg;

  // System clock and management clock rate
  localparam int CLK_HZ = 40_000_000;
  localparam int MDC_HZ = 2_500_000;
  localparam int MDC_HALF_INT = (CLK_HZ + 2 * MDC_HZ - 1) / (2 * MDC_HZ);
  localparam logic [3:0] MDC_HALF_M1 = 4'(MDC_HALF_INT - 1);

  // Management frame layout, first bit sent is bit 63
  localparam logic [5:0] MG_LAST_BIT = 6'h3F;
  localparam logic [5:0] MG_TA_BIT = 6'h2E;
  localparam logic [5:0] MG_DATA_BIT = 6'h30;
  localparam logic [31:0] MG_PREAMBLE = 32'hFFFF_FFFF;
  localparam logic [1:0] MG_START = 2'h1;
  localparam logic [1:0] MG_OP_RD = 2'h2;
  localparam logic [1:0] MG_OP_WR = 2'h1;
  localparam logic [1:0] MG_TA_WR = 2'h2;
  localparam logic [1:0] MG_TA_RD = 2'h3;
  localparam logic [15:0] MG_IDLE_DATA = 16'hFFFF;

  // Last slot index of a byte: two nibbles or four dibits
  localparam logic [1:0] MII_LAST_SLOT = 2'h1;
  localparam logic [1:0] RMII_LAST_SLOT = 2'h3;

  // Positions in the system-side synchroniser vector
  localparam int SY_CRS = 0;
  localparam int SY_COL = 1;
  localparam int SY_MDIO = 2;
  localparam int SY_ACK = 3;
  localparam int SY_UND = 4;
  localparam int SY_RXB = 5;
  localparam int SY_RXE = 6;
  localparam int SY_W = 7;

  // Values after reset
  localparam logic TX_READY_RST = 1'b1;
  localparam logic [1:0] RST_SYNC_RST = 2'h0;

  typedef enum logic [1:0] {
    ETHP_MG_IDLE = 2'b00,
    ETHP_MG_RUN = 2'b01
  } ethp_mg_t;

  function automatic logic [1:0] ethp_last_slot(input logic rmii);
    return rmii ? RMII_LAST_SLOT : MII_LAST_SLOT;
  endfunction : ethp_last_slot

  // Accept a synchronised level only once stages two and three agree
  function automatic logic ethp_agree(input logic s2, input logic s3,
                                      input logic held);
    return (s2 == s3) ? s3 : held;
  endfunction : ethp_agree

endpackage : ethp_pkg

// >>> logic/ethp_tx.sv
// Purpose: Transmit pin driver on the PHY transmit clock.
// Assumes: Byte offered by toggle, held stable until acknowledged.
// Notes: Low nibble or dibit goes out first.
`timescale 1ns/1ps
module ethp_tx (
  // Link clock and reset
  input wire logic i_tx_clk,
  input wire logic i_rst_n,
  // From the system domain
  input wire logic i_rmii_mode,
  input wire logic i_req_tog,
  input wire logic [7:0] i_byte,
  input wire logic i_last,
  output logic o_ack_tog,
  output logic o_und_tog,
  // Pins
  output logic [3:0] o_tx_data,
  output logic o_tx_en
);
  import ethp_pkg::*;

  logic [1:0] lrst_r;
  logic [1:0] s1_r, s2_r, s3_r;
  logic req_seen_r, req_seen_nxt, mode_r, mode_nxt, req_new;
  logic [7:0] hold_r, hold_nxt, sh_r, sh_nxt;
  logic hold_last_r, hold_last_nxt, hold_full_r, hold_full_nxt;
  logic cur_last_r, cur_last_nxt, en_nxt, ack_nxt, und_nxt, load;
  logic [1:0] slot_r, slot_nxt;
  logic [3:0] data_nxt;

  always_ff @(posedge i_tx_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      lrst_r <= RST_SYNC_RST;
    else
      lrst_r <= {lrst_r[0], 1'b1};
  end

  always_comb
  begin
    req_seen_nxt = ethp_agree(s2_r[0], s3_r[0], req_seen_r);
    req_new = req_seen_nxt ^ req_seen_r;
    // Mode only follows while the line is quiet
    // Also frozen while a byte waits, so a frame never starts mid-switch
    mode_nxt = (o_tx_en || hold_full_r) ? mode_r
             : ethp_agree(s2_r[1], s3_r[1], mode_r);
    en_nxt = o_tx_en;
    sh_nxt = sh_r;
    slot_nxt = slot_r;
    cur_last_nxt = cur_last_r;
    hold_nxt = hold_r;
    hold_last_nxt = hold_last_r;
    hold_full_nxt = hold_full_r;
    ack_nxt = o_ack_tog;
    und_nxt = o_und_tog;
    load = 1'b0;
    if (o_tx_en)
    begin
      if (slot_r == ethp_last_slot(mode_r))
      begin
        if (cur_last_r)
          en_nxt = 1'b0;
        else if (hold_full_r)
          load = 1'b1;
        else
        begin
          // Underrun: end the frame short rather than send stale data
          en_nxt = 1'b0;
          und_nxt = ~o_und_tog;
        end
      end
      else
      begin
        slot_nxt = slot_r + 2'h1;
        sh_nxt = mode_r ? {2'h0, sh_r[7:2]} : {4'h0, sh_r[7:4]};
      end
    end
    else if (hold_full_r)
    begin
      load = 1'b1;
      en_nxt = 1'b1; // [R7]
    end
    if (load)
    begin
      sh_nxt = hold_r;
      cur_last_nxt = hold_last_r;
      slot_nxt = 2'h0;
      hold_full_nxt = 1'b0;
      ack_nxt = ~o_ack_tog;
    end
    if (req_new)
    begin
      hold_nxt = i_byte;
      hold_last_nxt = i_last;
      hold_full_nxt = 1'b1;
    end
    // Upper lines stay low in the reduced mode
    if (!en_nxt)
      data_nxt = 4'h0;
    else if (mode_r)
      data_nxt = {2'h0, sh_nxt[1:0]}; // [R6]
    else
      data_nxt = sh_nxt[3:0]; // [R5]
  end

  always_ff @(posedge i_tx_clk or negedge lrst_r[1])
  begin
    if (!lrst_r[1])
    begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      s3_r <= 2'h0;
      req_seen_r <= 1'b0;
      mode_r <= 1'b0;
      hold_r <= 8'h00;
      hold_last_r <= 1'b0;
      hold_full_r <= 1'b0;
      sh_r <= 8'h00;
      slot_r <= 2'h0;
      cur_last_r <= 1'b0;
      o_tx_en <= 1'b0;
      o_tx_data <= 4'h0;
      o_ack_tog <= 1'b0;
      o_und_tog <= 1'b0;
    end
    else
    begin
      s1_r <= {i_rmii_mode, i_req_tog};
      s2_r <= s1_r;
      s3_r <= s2_r;
      req_seen_r <= req_seen_nxt;
      mode_r <= mode_nxt;
      hold_r <= hold_nxt;
      hold_last_r <= hold_last_nxt;
      hold_full_r <= hold_full_nxt;
      sh_r <= sh_nxt;
      slot_r <= slot_nxt;
      cur_last_r <= cur_last_nxt;
      o_tx_en <= en_nxt; // [R7]
      o_tx_data <= data_nxt; // [R5]
      o_ack_tog <= ack_nxt;
      o_und_tog <= und_nxt;
    end
  end

  a_rmii_upper_zero: assert property (@(posedge i_tx_clk) // [R6]
    disable iff (!lrst_r[1]) mode_r |-> o_tx_data[3:2] == 2'h0)
    else $error("upper transmit lines driven in reduced mode");

  a_tx_idle_quiet: assert property (@(posedge i_tx_clk) // [R7]
    disable iff (!lrst_r[1]) !o_tx_en |-> o_tx_data == 4'h0)
    else $error("transmit data not zero while enable is low");

  a_mii_two_nibbles: assert property (@(posedge i_tx_clk) // [R5]
    disable iff (!lrst_r[1])
    ($rose(o_tx_en) && !mode_r) |-> o_tx_en [*2])
    else $error("nibble mode byte shorter than two clocks");

endmodule : ethp_tx

// >>> logic/ethp_rx.sv
// Purpose: Receive pin sampler on the PHY receive or reference clock.
// Assumes: Pins change with this clock, so only the mode input is synchronised here.
// Notes: A partial byte at frame end is dropped.
`timescale 1ns/1ps
module ethp_rx (
  // Link clock and reset
  input wire logic i_rx_clk,
  input wire logic i_rst_n,
  input wire logic i_rmii_mode,
  // Pins
  input wire logic [3:0] i_rx_data,
  input wire logic i_rx_dv,
  input wire logic i_rx_err,
  // To the system domain
  output logic o_byte_tog,
  output logic [7:0] o_byte,
  output logic o_end_tog,
  output logic o_end_err
);
  import ethp_pkg::*;

  logic [1:0] lrst_r;
  logic m1_r, m2_r, m3_r, mode_r, mode_nxt;
  logic [3:0] d_q_r;
  logic dv_q_r, er_q_r, er_prev_r, take, err_seen;
  logic in_frame_r, in_frame_nxt, bad_r, bad_nxt;
  logic [7:0] asm_r, asm_nxt, byte_nxt;
  logic [1:0] slot_r, slot_nxt;
  logic btog_nxt, etog_nxt, eerr_nxt;

  always_ff @(posedge i_rx_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      lrst_r <= RST_SYNC_RST;
    else
      lrst_r <= {lrst_r[0], 1'b1};
  end

  always_comb
  begin
    // Frozen from the first valid sample so a frame keeps one width
    mode_nxt = (in_frame_r || dv_q_r) ? mode_r
             : ethp_agree(m2_r, m3_r, mode_r);
    // Valid may drop mid-nibble in reduced mode; end only on a boundary
    take = dv_q_r | (mode_r & in_frame_r & slot_r[0]); // [R13]
    err_seen = er_q_r & er_prev_r; // [R14]
    in_frame_nxt = in_frame_r;
    bad_nxt = bad_r;
    asm_nxt = asm_r;
    slot_nxt = slot_r;
    byte_nxt = o_byte;
    btog_nxt = o_byte_tog;
    etog_nxt = o_end_tog;
    eerr_nxt = o_end_err;
    if (take)
    begin
      in_frame_nxt = 1'b1;
      if (mode_r)
        asm_nxt = {d_q_r[1:0], asm_r[7:2]}; // [R11]
      else
        asm_nxt = {d_q_r, asm_r[7:4]}; // [R10]
      if (err_seen)
        bad_nxt = 1'b1; // [R14]
      if (slot_r == ethp_last_slot(mode_r))
      begin
        slot_nxt = 2'h0;
        byte_nxt = asm_nxt;
        btog_nxt = ~o_byte_tog;
      end
      else
        slot_nxt = slot_r + 2'h1;
    end
    else if (in_frame_r)
    begin
      in_frame_nxt = 1'b0;
      slot_nxt = 2'h0;
      eerr_nxt = bad_r | err_seen; // [R14]
      etog_nxt = ~o_end_tog;
      bad_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_rx_clk or negedge lrst_r[1])
  begin
    if (!lrst_r[1])
    begin
      m1_r <= 1'b0;
      m2_r <= 1'b0;
      m3_r <= 1'b0;
      mode_r <= 1'b0;
      d_q_r <= 4'h0;
      dv_q_r <= 1'b0;
      er_q_r <= 1'b0;
      er_prev_r <= 1'b0;
      in_frame_r <= 1'b0;
      bad_r <= 1'b0;
      asm_r <= 8'h00;
      slot_r <= 2'h0;
      o_byte <= 8'h00;
      o_byte_tog <= 1'b0;
      o_end_tog <= 1'b0;
      o_end_err <= 1'b0;
    end
    else
    begin
      m1_r <= i_rmii_mode;
      m2_r <= m1_r;
      m3_r <= m2_r;
      mode_r <= mode_nxt;
      d_q_r <= i_rx_data;
      dv_q_r <= i_rx_dv;
      er_q_r <= i_rx_err;
      er_prev_r <= er_q_r;
      in_frame_r <= in_frame_nxt;
      bad_r <= bad_nxt;
      asm_r <= asm_nxt;
      slot_r <= slot_nxt;
      o_byte <= byte_nxt;
      o_byte_tog <= btog_nxt;
      o_end_tog <= etog_nxt;
      o_end_err <= eerr_nxt;
    end
  end

  a_rx_err_mark: assert property (@(posedge i_rx_clk) // [R14]
    disable iff (!lrst_r[1]) (take && er_q_r && er_prev_r) |=> bad_r)
    else $error("held receive error not recorded for frame");

endmodule : ethp_rx

// >>> verification/ethp_phy_model.sv
// Purpose: PHY stand-in at the pins of the MII/RMII port.
// Assumes: One link clock feeds both link clock ports.
// Notes: Released lines idle at the inverse of their last value.
`timescale 1ns/1ps
module ethp_phy_model (
  // Link clock and mode
  input wire logic i_clk,
  input wire logic i_rmii,
  // Transmit pins
  input wire logic [3:0] i_txd,
  input wire logic i_txen,
  // Receive pins
  output logic [3:0] o_rxd,
  output logic o_rxdv,
  output logic o_rxer,
  // Management pins
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe
);
  logic [7:0] sr;
  logic [2:0] k = 3'h0;
  logic [5:0] n = 6'h00;
  logic rd = 1'b0;
  logic [15:0] wd;
  logic [15:0] rdat = 16'hB26D;
  int bad = 0;
  logic [7:0] txq[$];

  initial
  begin
    o_rxd = 4'h0;
    o_rxdv = 1'b0;
    o_rxer = 1'b0;
    o_mdio = 1'b0;
    o_mdio_oe = 1'b0;
  end

  // Capture on rising transmit clock, low slot first
  always @(posedge i_clk)
    if (i_txen === 1'b1)
    begin
      if (i_rmii && i_txd[3:2] !== 2'h0)
        bad++;
      sr = i_rmii ? {i_txd[1:0], sr[7:2]} : {i_txd, sr[7:4]};
      k = k + 3'h1;
      if (k == (i_rmii ? 3'h4 : 3'h2))
      begin
        txq.push_back(sr);
        k = 3'h0;
      end
    end
    else if (i_txd !== 4'h0)
      bad++;

  // Valid drops only on a byte, hence nibble, boundary
  task automatic send(input logic [15:0] w, input int nb, input logic err);
    int s;
    for (int i = 0; i < nb; i++)
      for (s = 0; s < (i_rmii ? 4 : 2); s++)
      begin
        @(negedge i_clk);
        o_rxdv = 1'b1;
        if (i_rmii)
          o_rxd = {~o_rxd[3:2], w[8*i+2*s +: 2]};
        else
          o_rxd = w[8*i+4*s +: 4];
        o_rxer = err && i == 0 && s < 2;
      end
    @(negedge i_clk);
    o_rxdv = 1'b0;
    o_rxer = 1'b0;
    o_rxd = ~o_rxd;
  endtask : send

  // Frame bit 34 is the first op bit: high for a read
  always @(posedge i_mdc)
  begin
    if (n == 6'h22)
      rd <= i_mdio;
    if (n >= 6'h30)
      wd <= {wd[14:0], i_mdio};
    n <= n + 6'h01;
  end

  // Change data after falling edge so it is stable at the rise
  always @(negedge i_mdc)
  begin
    o_mdio_oe <= rd && n >= 6'h2F;
    o_mdio <= (n == 6'h2F) ? 1'b0 : rdat[6'h3F - n];
  end
endmodule : ethp_phy_model

// >>> verification/ethp_port_tb.sv
// Purpose: Self-checking bench for the PHY pin port.
// Assumes: Link clock of 160 ns drives both link clock ports.
// Notes: Mode changes only between frames.
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    compares++; \
    if ((a) !== (e)) \
    begin \
      miscompares++; \
      $display("wrong value at %0t: got %h want %h", $time, a, e); \
    end \
  end
module ethp_port_tb;
  logic clk = 0;
  logic lclk = 0;
  logic arst_n = 0;
  logic mode = 0;
  logic tx_valid = 0;
  logic [7:0] tx_byte = 8'h00;
  logic tx_last = 0;
  logic mg_start = 0;
  logic mg_read = 0;
  logic [15:0] mg_wdata = 16'h0000;
  logic col = 0;
  logic crs = 0;
  logic tx_ready, rx_valid, rx_end, rx_crc, busy, done, mdc, mdio_o, mdio_oe;
  logic collision, carrier, txen, rxdv, rxer, p_d, p_oe, und;
  logic [7:0] rx_byte;
  logic [15:0] rdata;
  logic [3:0] txd, rxd;
  wire mdio;
  int compares = 0;
  int miscompares = 0;
  int cycles = 0;
  int ends = 0;
  int errs = 0;
  int unds = 0;
  logic [7:0] rxq[$];

  // Pull-up holds the line high when nobody drives it
  assign mdio = mdio_oe ? mdio_o : (p_oe ? p_d : 1'b1);

  always #12.5 clk = ~clk;

  initial
  begin
    #37;
    forever #80 lclk = ~lclk;
  end

  ethp_port ethp_port_i (.i_clk(clk), .i_arst_n(arst_n),
    .i_rmii_mode(mode), .i_tx_link_clk(lclk), .i_rx_link_clk(lclk),
    .i_tx_valid(tx_valid), .i_tx_byte(tx_byte), .i_tx_last(tx_last),
    .o_tx_ready(tx_ready), .o_tx_underrun(und), .o_rx_valid(rx_valid),
    .o_rx_byte(rx_byte), .o_rx_end(rx_end), .o_rx_crc_err(rx_crc),
    .i_mgmt_start(mg_start), .i_mgmt_read(mg_read), .i_mgmt_phy(5'h03),
    .i_mgmt_reg(5'h1A), .i_mgmt_wdata(mg_wdata), .o_mgmt_busy(busy),
    .o_mgmt_done(done), .o_mgmt_rdata(rdata), .o_collision(collision),
    .o_carrier(carrier), .o_mgmt_clock_out(mdc), .i_mgmt_data_io(mdio),
    .o_mgmt_data_io(mdio_o), .o_mgmt_data_oe(mdio_oe),
    .i_collision_in(col), .i_carrier_sense_in(crs), .o_tx_data_bus(txd),
    .o_tx_enable_out(txen), .i_rx_data_bus(rxd), .i_rx_data_valid(rxdv),
    .i_rx_error_in(rxer));

  ethp_phy_model phy_i (.i_clk(lclk), .i_rmii(mode), .i_txd(txd),
    .i_txen(txen), .o_rxd(rxd), .o_rxdv(rxdv), .o_rxer(rxer),
    .i_mdc(mdc), .i_mdio(mdio), .o_mdio(p_d), .o_mdio_oe(p_oe));

  // Away from the edge so pulses are read settled
  always @(negedge clk)
  begin
    if (rx_valid === 1'b1)
      rxq.push_back(rx_byte);
    if (rx_end === 1'b1)
    begin
      ends++;
      errs += (rx_crc !== 1'b0);
    end
    if (und !== 1'b0)
      unds++;
  end

  task wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  task step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic put(input logic [7:0] b, input logic l);
    while (tx_ready !== 1'b1)
      step();
    tx_valid = 1'b1;
    tx_byte = b;
    tx_last = l;
    step();
    tx_valid = 1'b0;
  endtask : put

  task automatic lines;
    col = 1'b1;
    repeat (6) step();
    `CHK(collision, 1'b1)
    `CHK(carrier, 1'b0)
    col = 1'b0;
    crs = 1'b1;
    repeat (6) step();
    `CHK(collision, 1'b0)
    `CHK(carrier, 1'b1)
  endtask : lines

  task automatic txrx(input logic m, input logic [7:0] a, input logic [7:0] b);
    mode = m;
    repeat (60) step();
    phy_i.txq.delete();
    rxq.delete();
    ends = 0;
    errs = 0;
    unds = 0;
    put(a, 1'b0);
    put(b, 1'b1);
    while (phy_i.txq.size() < 2 || txen !== 1'b0)
      step();
    `CHK(phy_i.txq[0], a)
    `CHK(phy_i.txq[1], b)
    phy_i.send({a, b}, 2, 1'b0);
    while (ends == 0)
      step();
    `CHK(rxq.size(), 2)
    `CHK(rxq[0], b)
    `CHK(rxq[1], a)
    `CHK(errs, 0)
    `CHK(phy_i.bad, 0)
    // Ack round trip outlasts a byte on this link clock: frame cut after the first byte
    `CHK(unds, 1)
  endtask : txrx

  task automatic rx_err;
    ends = 0;
    errs = 0;
    phy_i.send(16'h00A5, 1, 1'b1);
    while (ends == 0)
      step();
    `CHK(errs, 1)
  endtask : rx_err

  task automatic mg(input logic rd, input logic [15:0] w);
    int n = 0;
    mg_start = 1'b1;
    mg_read = rd;
    mg_wdata = w;
    step();
    mg_start = 1'b0;
    while (done !== 1'b1)
    begin
      step();
      n++;
    end
    `CHK(n inside {[1024:1026]}, 1'b1)
    if (rd)
      `CHK(rdata, 16'hB26D)
    else
      `CHK(phy_i.wd, w)
    `CHK(mdc, 1'b0)
  endtask : mg

  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (40) step();
    lines();
    txrx(1'b0, 8'h5A, 8'hC3);
    rx_err();
    txrx(1'b1, 8'h1E, 8'hB4);
    mode = 1'b0;
    mg(1'b0, 16'h9C41);
    mg(1'b1, 16'h0000);
    wrap_up();
  end
endmodule : ethp_port_tb
